// >>> src/quad_io_read_engine.sv
`timescale 1ns/100ps
`include "quad_read_map.svh"

// Behaviour
// - EBh takes 3 or 4 address bytes by address-length bit; ECh always 4.
// - Single-rate address arrives one nibble per serial clock rising edge.
// - After mode, latency-field dummy cycles pass with data lines ignored.
// - Single-rate data leaves one nibble per clock, changing on falling edges.
// - Address increments per output byte and wraps from top to zero.
// - Single-rate mode byte Ax keeps continuous mode; next frame starts at address.
// - Single-rate continuous mode ends after other mode byte or mode reset.
// - Single-rate mode byte takes exactly two clocks after the address.
// - Four-wire instruction mode sends instruction nibbles on rising edges.
// - EDh takes 3 or 4 address bytes by address-length bit; EEh always 4.
// - Double-rate address, mode and data move a nibble on every edge.
// - Double-rate complementary mode nibbles enter continuous mode.
// - Double-rate continuous mode ends after other mode byte or mode reset.
// - Preamble drives the four cycles just before first double-rate data.
// - Preamble byte goes MSB first, one bit per edge, on all four lines.
module quad_io_read_engine
    import quad_read_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        sclk,
    input  wire logic        csn,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOe,
    input  wire logic        quadEnable,
    input  wire logic        addr4Byte,
    input  wire logic        fourWireInstr,
    input  wire logic [3:0]  latency,
    input  wire logic        preambleEnable,
    input  wire logic [7:0]  preamble,
    input  wire logic        modeReset,
    output logic      [31:0] memAddr,
    input  wire logic [7:0]  memData,
    output logic             continuousMode,
    output logic             continuousDdr
);
    link_sample_if lk ();

    link_sampler u_sampler (
        .clock  (clock),
        .resetn (resetn),
        .sclk   (sclk),
        .csn    (csn),
        .ioIn   (ioIn),
        .lk     (lk)
    );

    phase_t      phase;
    logic [3:0]  cnt;
    logic [7:0]  instr;
    logic [31:0] addr;
    logic [7:0]  modeByte;
    logic        modeDone;
    logic        isDdr;
    logic [3:0]  addrNib;
    logic        loNext;
    logic [1:0]  preSlot;
    logic        preOn;

    wire        rise      = lk.sclkRise & lk.csnLow;
    wire        fall      = lk.sclkFall & lk.csnLow;
    // Double-rate captures on both edges; a field opens on a rise, never on the
    // fall that closes the single-rate instruction cycle
    wire        capEdge   = rise | (isDdr & fall & cnt[0]);
    wire        dataEdge  = isDdr ? (rise | fall) : fall;
    wire        dummyEdge = isDdr ? rise : fall;
    wire [7:0]  instrNext = fourWireInstr ? {instr[3:0], lk.ioData}
                                          : {instr[6:0], lk.ioData[0]};
    wire        instrDone = (cnt == (fourWireInstr ? `INSTR_FOUR_WIRE_LAST
                                                   : `INSTR_SERIAL_LAST));
    wire        cmdSdr    = (instrNext == `QUAD_IO_READ_CMD)
                          | (instrNext == `QUAD_IO_READ_4BYTE_CMD);
    wire        cmdDdr    = (instrNext == `DDR_IO_READ_CMD)
                          | (instrNext == `DDR_IO_READ_4BYTE_CMD);
    wire        cmd4Byte  = (instrNext == `QUAD_IO_READ_4BYTE_CMD)
                          | (instrNext == `DDR_IO_READ_4BYTE_CMD);
    wire        cmdTaken  = quadEnable & (cmdSdr | cmdDdr);
    wire [3:0]  nextNib   = (cmd4Byte | addr4Byte) ? `ADDR4_NIBBLES
                                                   : `ADDR3_NIBBLES;
    wire [31:0] addrShift = {addr[27:0], lk.ioData};
    wire [3:0]  remaining = latency - cnt;
    wire        preWindow = isDdr & preambleEnable & (remaining != 4'h0)
                          & (remaining <= `PREAMBLE_CYCLES);
    wire [1:0]  slotNow   = 2'(remaining - 4'h1);
    wire [31:0] addrInc   = (addrNib == `ADDR4_NIBBLES) ? memAddr + 32'h1
                          : ((memAddr + 32'h1) & `ADDR3_MASK);
    wire        keepSdr   = (modeByte[7:4] == `MODE_KEEP_NIBBLE);
    wire        keepDdr   = (modeByte[7:4] == ~modeByte[3:0]);

    // Sequencing of one frame
    always_ff @(posedge clock) begin
        if (!resetn) begin
            phase    <= ST_IDLE;
            cnt      <= 4'h0;
            isDdr    <= 1'b0;
            addrNib  <= `ADDR3_NIBBLES;
            modeDone <= 1'b0;
        end else if (lk.csnFall) begin
            // Continuous mode skips the instruction byte
            phase    <= continuousMode ? ST_ADDR : ST_INSTR;
            cnt      <= 4'h0;
            isDdr    <= continuousDdr;
            modeDone <= 1'b0;
        end else if (!lk.csnLow) begin
            phase    <= ST_IDLE;
        end else begin
            case (phase)
                ST_INSTR: begin
                    if (rise) begin
                        cnt <= cnt + 4'h1;
                        if (instrDone) begin
                            phase   <= cmdTaken ? ST_ADDR : ST_IGNORE;
                            cnt     <= 4'h0;
                            isDdr   <= cmdDdr;
                            addrNib <= nextNib;
                        end
                    end
                end
                ST_ADDR: begin
                    if (capEdge) begin
                        cnt <= cnt + 4'h1;
                        if (cnt == addrNib - 4'h1) begin
                            phase <= ST_MODE;
                            cnt   <= 4'h0;
                        end
                    end
                end
                ST_MODE: begin
                    if (capEdge) begin
                        cnt <= cnt + 4'h1;
                        if (cnt == `MODE_NIBBLE_LAST) begin
                            phase    <= ST_DUMMY;
                            cnt      <= 4'h0;
                            modeDone <= 1'b1;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (dummyEdge) begin
                        if (remaining == 4'h0) begin
                            phase <= ST_DATA;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Address, instruction and mode shifting
    always_ff @(posedge clock) begin
        if (!resetn) begin
            instr    <= 8'h00;
            addr     <= 32'h0;
            modeByte <= 8'h00;
            memAddr  <= 32'h0;
        end else if (lk.csnFall) begin
            instr    <= 8'h00;
            addr     <= 32'h0;
        end else begin
            if (phase == ST_INSTR && rise) instr <= instrNext;
            if (phase == ST_ADDR && capEdge) addr <= addrShift;
            if (phase == ST_MODE && capEdge) modeByte <= {modeByte[3:0], lk.ioData};
            // Array lookup starts as soon as the address is whole
            if (phase == ST_MODE) memAddr <= addr;
            else if (phase == ST_DATA && dataEdge && loNext) memAddr <= addrInc;
        end
    end

    // Pin drive: preamble, then byte data high nibble first
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ioOut   <= 4'h0;
            ioOe    <= 4'h0;
            loNext  <= 1'b0;
            preSlot <= 2'h0;
            preOn   <= 1'b0;
        end else if (!lk.csnLow || lk.csnFall) begin
            ioOe    <= 4'h0;
            loNext  <= 1'b0;
            preOn   <= 1'b0;
        end else if (phase == ST_DUMMY && dummyEdge) begin
            if (remaining == 4'h0) begin
                ioOut  <= memData[7:4];
                ioOe   <= 4'hF;
                loNext <= 1'b1;
                preOn  <= 1'b0;
            end else if (preWindow) begin
                ioOut   <= {4{preamble[{slotNow, 1'b1}]}};
                ioOe    <= 4'hF;
                preSlot <= slotNow;
                preOn   <= 1'b1;
            end
        end else if (phase == ST_DUMMY && preOn && fall) begin
            ioOut <= {4{preamble[{preSlot, 1'b0}]}};
        end else if (phase == ST_DATA && dataEdge) begin
            ioOut  <= loNext ? memData[3:0] : memData[7:4];
            loNext <= ~loNext;
        end
    end

    // Continuous-mode state survives between frames
    always_ff @(posedge clock) begin
        if (!resetn) begin
            continuousMode <= 1'b0;
            continuousDdr  <= 1'b0;
        end else if (modeReset) begin
            continuousMode <= 1'b0;
        end else if (lk.csnRise && modeDone) begin
            // A frame cut short before the mode byte leaves the state alone
            continuousMode <= isDdr ? keepDdr : keepSdr;
            continuousDdr  <= isDdr;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence instrEnd4;
        phase == ST_INSTR && rise && instrDone && cmdTaken && cmd4Byte;
    endsequence

    sequence sdrModeEnd;
        phase == ST_MODE && !isDdr && rise && cnt == `MODE_NIBBLE_LAST;
    endsequence

    addr_len_a: assert property (instrEnd4 |=> addrNib == `ADDR4_NIBBLES)
        else $error("four-byte command did not select eight address nibbles");

    addr_nibble_a: assert property (phase == ST_ADDR && rise |=> addr[3:0] == $past(lk.ioData))
        else $error("address nibble not shifted in on rising edge");

    mode_len_a: assert property (sdrModeEnd |=> phase == ST_DUMMY && modeDone)
        else $error("single-rate mode byte did not end after two clocks");

    dummy_quiet_a: assert property (phase == ST_DUMMY && !isDdr |-> ioOe == 4'h0)
        else $error("device drove lines during single-rate dummy cycles");

    fall_only_a: assert property (phase == ST_DATA && !isDdr && !fall && lk.csnLow
                                  && !lk.csnFall |=> $stable(ioOut))
        else $error("single-rate data changed away from a falling edge");

    addr_wrap_a: assert property (phase == ST_DATA && dataEdge && loNext
                                  && addrNib == `ADDR4_NIBBLES && memAddr == 32'hFFFFFFFF
                                  |=> memAddr == 32'h0)
        else $error("address did not wrap to zero");

    sdr_keep_a: assert property (lk.csnRise && modeDone && !isDdr && keepSdr && !modeReset
                                 |=> continuousMode)
        else $error("single-rate keep mode byte did not hold continuous mode");

    cont_start_a: assert property (lk.csnFall && continuousMode
                                   |=> phase == ST_ADDR)
        else $error("continuous frame did not start at address");

    mode_exit_a: assert property (modeReset |=> !continuousMode)
        else $error("mode reset did not leave continuous mode");

    ddr_keep_a: assert property (lk.csnRise && modeDone && isDdr && !modeReset
                                 |=> continuousMode == $past(keepDdr) && continuousDdr)
        else $error("double-rate complementary mode byte not honoured");

    ddr_exit_a: assert property (lk.csnRise && modeDone && isDdr && !keepDdr
                                 |=> !continuousMode)
        else $error("double-rate continuous mode not left");

    pre_drive_a: assert property (phase == ST_DUMMY && dummyEdge && preWindow && lk.csnLow
                                  && !lk.csnFall |=> ioOe == 4'hF)
        else $error("preamble not driven in last four dummy cycles");

    pre_value_a: assert property (phase == ST_DUMMY && dummyEdge && preWindow && lk.csnLow
                                  && !lk.csnFall
                                  |=> ioOut == {4{preamble[{$past(slotNow), 1'b1}]}})
        else $error("preamble bit not on all four lines");

    four_wire_a: assert property (phase == ST_INSTR && fourWireInstr && rise
                                  && cnt == `INSTR_FOUR_WIRE_LAST && lk.csnLow
                                  && !lk.csnFall |=> phase != ST_INSTR)
        else $error("four-wire instruction took more than two clocks");

endmodule : quad_io_read_engine

// >>> src/quad_read_map.svh
`ifndef QUAD_READ_MAP_SVH
`define QUAD_READ_MAP_SVH

// Instruction codes
`define QUAD_IO_READ_CMD        8'hEB
`define QUAD_IO_READ_4BYTE_CMD  8'hEC
`define DDR_IO_READ_CMD         8'hED
`define DDR_IO_READ_4BYTE_CMD   8'hEE

// Mode byte upper nibble that keeps single-rate continuous mode
`define MODE_KEEP_NIBBLE        4'hA

// Address length in nibbles, and three-byte address mask
`define ADDR3_NIBBLES           4'h6
`define ADDR4_NIBBLES           4'h8
`define ADDR3_MASK              32'h00FFFFFF

// Counts of link edges
`define INSTR_SERIAL_LAST       4'h7
`define INSTR_FOUR_WIRE_LAST    4'h1
`define MODE_NIBBLE_LAST        4'h1
`define PREAMBLE_CYCLES         4'h4

`endif

// >>> src/quad_read_pkg.sv
package quad_read_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } phase_t;

endpackage : quad_read_pkg

// >>> src/link_sample_if.sv
`timescale 1ns/100ps

interface link_sample_if;
    logic       sclkRise;
    logic       sclkFall;
    logic       csnLow;
    logic       csnFall;
    logic       csnRise;
    logic [3:0] ioData;

    modport sampler (output sclkRise, output sclkFall, output csnLow,
                     output csnFall, output csnRise, output ioData);
    modport engine  (input sclkRise, input sclkFall, input csnLow,
                     input csnFall, input csnRise, input ioData);
endinterface : link_sample_if

// >>> src/link_sampler.sv
`timescale 1ns/100ps

module link_sampler (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       sclk,
    input  wire logic       csn,
    input  wire logic [3:0] ioIn,
    link_sample_if.sampler  lk
);
    logic [2:0] sclkPipe;
    logic [2:0] csnPipe;
    logic [3:0] ioMeta;
    logic [3:0] ioSync;

    // Stage 0 feeds stage 1 only; edges are found between stages 1 and 2
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sclkPipe <= 3'h0;
            csnPipe  <= 3'h7;
            ioMeta   <= 4'h0;
            ioSync   <= 4'h0;
        end else begin
            sclkPipe <= {sclkPipe[1:0], sclk};
            csnPipe  <= {csnPipe[1:0], csn};
            ioMeta   <= ioIn;
            ioSync   <= ioMeta;
        end
    end

    assign lk.sclkRise = sclkPipe[1] & ~sclkPipe[2];
    assign lk.sclkFall = ~sclkPipe[1] & sclkPipe[2];
    assign lk.csnLow   = ~csnPipe[1];
    assign lk.csnFall  = ~csnPipe[1] & csnPipe[2];
    assign lk.csnRise  = csnPipe[1] & ~csnPipe[2];
    assign lk.ioData   = ioSync;

endmodule : link_sampler

// >>> verification/quad_host_model.sv
`timescale 1ns/100ps

module quad_host_model (
    output logic            sclk,
    output logic            csn,
    output logic      [3:0] ioIn,
    input  wire logic [3:0] ioOut,
    input  wire logic [3:0] ioOe
);
    logic [3:0] hostVal;
    logic       hostEn;
    logic [3:0] junk;
    logic [3:0] rs [0:31];
    logic [3:0] fs [0:31];

    // A released line shows the inverse of its last value, so stale data cannot match
    assign ioIn = (ioOe & ioOut) | (~ioOe & (hostEn ? hostVal : ~hostVal));

    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        hostVal = 4'h0;
        hostEn = 1'b0;
    end

    // 160 ns period keeps far below both rate ceilings; pins sampled just before each edge
    task automatic cycle(input logic [3:0] rd, input logic [3:0] fd, input logic drv,
                         output logic [3:0] sr, output logic [3:0] sf);
        hostEn = drv;
        if (drv) hostVal = rd;
        #40;
        sr = ioIn;
        sclk = 1'b1;
        #40;
        if (drv) hostVal = fd;
        #40;
        sf = ioIn;
        sclk = 1'b0;
        #40;
    endtask : cycle

    task automatic frame(input logic ddr, input logic [7:0] cmd, input logic sendCmd,
                         input logic fourWire, input int nNib, input logic [31:0] addr,
                         input logic [7:0] mode, input int nCyc);
        logic [7:0]  c;
        logic [31:0] sh;
        logic [3:0]  a;
        int          i;
        c = cmd;
        sh = addr << (32 - 4 * nNib);
        csn = 1'b0;
        #80;
        if (sendCmd) begin
            for (i = 0; i < (fourWire ? 2 : 8); i++) begin
                a = fourWire ? c[7:4] : {3'b000, c[7]};
                c = fourWire ? c << 4 : c << 1;
                cycle(a, a, 1'b1, junk, junk);
            end
        end
        for (i = 0; i < (ddr ? nNib / 2 : nNib); i++) begin
            cycle(sh[31:28], ddr ? sh[27:24] : sh[31:28], 1'b1, junk, junk);
            sh = ddr ? sh << 8 : sh << 4;
        end
        if (ddr) begin
            cycle(mode[7:4], mode[3:0], 1'b1, junk, junk);
        end else begin
            cycle(mode[7:4], mode[7:4], 1'b1, junk, junk);
            cycle(mode[3:0], mode[3:0], 1'b1, junk, junk);
        end
        // Lines released from the first dummy cycle on
        for (i = 1; i <= nCyc; i++) begin
            cycle(4'h0, 4'h0, 1'b0, rs[i], fs[i]);
        end
        csn = 1'b1;
        #320;
    endtask : frame
endmodule : quad_host_model

// >>> verification/quad_io_read_engine_tb_top.sv
`timescale 1ns/100ps

module quad_io_read_engine_tb_top;
    logic        clock;
    logic        resetn;
    logic        sclk;
    logic        csn;
    logic [3:0]  ioIn;
    logic [3:0]  ioOut;
    logic [3:0]  ioOe;
    logic        quadEnable;
    logic        addr4Byte;
    logic        fourWireInstr;
    logic [3:0]  latency;
    logic        preambleEnable;
    logic [7:0]  preamble;
    logic        modeReset;
    logic [31:0] memAddr;
    logic [7:0]  memData;
    logic        continuousMode;
    logic        continuousDdr;
    logic        oeSeen;
    int          err_total = 0;
    int          checks_done = 0;
    int          cycles = 0;

    // Content mixes two address bytes so a wrong wrap or increment shows
    assign memData = memAddr[7:0] ^ memAddr[15:8] ^ 8'hC3;

    quad_io_read_engine u_dut (.clock(clock), .resetn(resetn), .sclk(sclk), .csn(csn),
        .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable),
        .addr4Byte(addr4Byte), .fourWireInstr(fourWireInstr), .latency(latency),
        .preambleEnable(preambleEnable), .preamble(preamble), .modeReset(modeReset),
        .memAddr(memAddr), .memData(memData), .continuousMode(continuousMode),
        .continuousDdr(continuousDdr));

    quad_host_model u_host (.sclk(sclk), .csn(csn), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (ioOe !== 4'h0) oeSeen <= 1'b1;
        if (cycles == 40000) begin
            err_total++;
            finish_test();
        end
    end

    function automatic logic [7:0] memByte(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hC3;
    endfunction : memByte

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cfg(input logic q, input logic a4, input logic fw, input logic [3:0] lat,
                       input logic pe, input logic [7:0] pat);
        @(posedge clock);
        #1;
        quadEnable = q;
        addr4Byte = a4;
        fourWireInstr = fw;
        latency = lat;
        preambleEnable = pe;
        preamble = pat;
    endtask : cfg

    task automatic pulseReset;
        @(posedge clock);
        #1;
        modeReset = 1'b1;
        @(posedge clock);
        #1;
        modeReset = 1'b0;
        repeat (3) @(posedge clock);
    endtask : pulseReset

    task automatic checkSdr(input int l, input logic [31:0] a0, input logic [31:0] m);
        check({u_host.rs[l + 1], u_host.rs[l + 2]}, memByte(a0));
        check({u_host.rs[l + 3], u_host.rs[l + 4]}, memByte((a0 + 1) & m));
    endtask : checkSdr

    task automatic checkDdr(input int l, input logic [31:0] a0, input logic [7:0] p);
        int r;
        for (r = 4; r >= 1; r--) begin
            check(u_host.fs[l - r + 1], {4{p[2 * r - 1]}});
            check(u_host.rs[l - r + 2], {4{p[2 * r - 2]}});
        end
        check({u_host.fs[l + 1], u_host.rs[l + 2]}, memByte(a0));
        check({u_host.fs[l + 2], u_host.rs[l + 3]}, memByte(a0 + 1));
    endtask : checkDdr

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        resetn = 1'b0;
        modeReset = 1'b0;
        oeSeen = 1'b0;
        quadEnable = 1'b1;
        addr4Byte = 1'b0;
        fourWireInstr = 1'b0;
        latency = 4'h3;
        preambleEnable = 1'b0;
        preamble = 8'h00;
        repeat (6) @(posedge clock);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge clock);
        u_host.frame(1'b0, 8'hEB, 1'b1, 1'b0, 6, 32'h00123456, 8'hA5, 7);
        checkSdr(3, 32'h00123456, 32'h00FFFFFF);
        check(continuousMode, 1'b1);
        u_host.frame(1'b0, 8'h00, 1'b0, 1'b0, 6, 32'h00FFFFFF, 8'h3C, 7);
        checkSdr(3, 32'h00FFFFFF, 32'h00FFFFFF);
        check(continuousMode, 1'b0);
        cfg(1'b1, 1'b0, 1'b1, 4'h1, 1'b0, 8'h00);
        u_host.frame(1'b0, 8'hEC, 1'b1, 1'b1, 8, 32'hFFFFFFFF, 8'hA0, 5);
        checkSdr(1, 32'hFFFFFFFF, 32'hFFFFFFFF);
        check(continuousMode, 1'b1);
        pulseReset();
        check(continuousMode, 1'b0);
        cfg(1'b1, 1'b1, 1'b0, 4'h5, 1'b1, 8'h34);
        u_host.frame(1'b1, 8'hED, 1'b1, 1'b0, 8, 32'h89ABCDEF, 8'h5A, 8);
        checkDdr(5, 32'h89ABCDEF, 8'h34);
        check({continuousMode, continuousDdr}, 2'b11);
        u_host.frame(1'b1, 8'h00, 1'b0, 1'b0, 8, 32'h000010FE, 8'h55, 8);
        checkDdr(5, 32'h000010FE, 8'h34);
        check(continuousMode, 1'b0);
        cfg(1'b1, 1'b0, 1'b1, 4'h4, 1'b1, 8'hC9);
        u_host.frame(1'b1, 8'hEE, 1'b1, 1'b1, 8, 32'h01020304, 8'hC3, 7);
        checkDdr(4, 32'h01020304, 8'hC9);
        check({continuousMode, continuousDdr}, 2'b11);
        pulseReset();
        check(continuousMode, 1'b0);
        cfg(1'b0, 1'b0, 1'b0, 4'h3, 1'b0, 8'h00);
        oeSeen = 1'b0;
        u_host.frame(1'b0, 8'hEB, 1'b1, 1'b0, 6, 32'h00000100, 8'hA0, 7);
        check({oeSeen, continuousMode}, 2'b00);
        finish_test();
    end
endmodule : quad_io_read_engine_tb_top
